// *** itw_pkg.sv ***
// Package: constants and types of the interval timer and watchdog
package itw_pkg;
	// Bus address layout
	localparam int ADDR_W = 10;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_INTERVAL_CTRL = 8'h8B;
	localparam logic [IDX_W-1:0] IDX_INTERVAL_COUNT = 8'h8C;
	localparam logic [IDX_W-1:0] IDX_WDOG_MODE = 8'h8D;
	localparam logic [IDX_W-1:0] IDX_WDOG_MATCH = 8'h8E;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h90;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h91;
	// Field positions
	localparam int CTL_FLAG = 7;
	localparam int CTL_CLEAR = 3;
	localparam int CTL_SEL_LSB = 0;
	localparam int SEL_W = 3;
	localparam int MODE_EN = 7;
	localparam int MODE_RST = 6;
	localparam int MODE_CLR = 5;
	localparam int MODE_IRQ = 0;
	localparam int ST_OVF = 0;
	localparam int ST_MATCH = 1;
	localparam int ST_W = 2;
	// Reset values, count step and bus response codes
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h5;
	localparam logic [REG_W-1:0] MATCH_RESET = 8'hFF;
	localparam logic [REG_W-1:0] COUNT_RESET = 8'h00;
	localparam logic [REG_W-1:0] COUNT_STEP = 8'h01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing: shortest overflow period is two ticks of the timer clock
	localparam real PERIOD_MIN_MS = 0.512;
	localparam real CLK_FREQ_KHZ = 200000.0;
	localparam int TICKS_PER_MIN_PERIOD = 2;
	localparam int TICK_CYCLES_DEF = int'(PERIOD_MIN_MS * CLK_FREQ_KHZ) / TICKS_PER_MIN_PERIOD;

	typedef struct packed {
		logic enable;
		logic reset_on;
		logic [REG_W-1:0] match;
	} itw_wdog_cfg_t;

	typedef struct packed {
		logic [REG_W-1:0] count;
		logic overflow;
	} itw_interval_t;

	function automatic logic [IDX_W-1:0] itw_index(input logic [ADDR_W-1:0] addr);
		return addr[IDX_LSB +: IDX_W];
	endfunction

	function automatic logic itw_mapped(input logic [IDX_W-1:0] idx);
		return idx inside {IDX_INTERVAL_CTRL, IDX_INTERVAL_COUNT, IDX_WDOG_MODE,
			IDX_WDOG_MATCH, IDX_IRQ_STATUS, IDX_IRQ_MASK};
	endfunction
endpackage

// *** itw_interval_timer.sv ***
// Free-running interval timer with selectable overflow period
`timescale 1ns/1ps
module itw_interval_timer
	import itw_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [SEL_W-1:0] period_sel,
	input wire logic clear,
	output itw_interval_t status
);
	localparam int PW = $clog2(TICK_CYCLES);
	localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);
	localparam logic [PW-1:0] PRESC_STEP = PW'(1);

	logic [PW-1:0] presc;
	logic [PW-1:0] next_presc;
	logic [REG_W-1:0] count;
	logic [REG_W-1:0] next_count;
	logic [REG_W-1:0] mask;
	logic ovf;
	logic next_ovf;
	logic tick;

	// Overflow when the low sel+1 counter bits are all ones at a tick
	always_comb begin
		tick = (presc == TICK_LAST);
		mask = REG_W'((9'h002 << period_sel) - 9'h001);
		next_presc = tick ? '0 : presc + PRESC_STEP;
		next_ovf = tick && !clear && ((count & mask) == mask);
		if (clear) begin
			next_count = COUNT_RESET;
		end else if (tick) begin
			next_count = count + COUNT_STEP;
		end else begin
			next_count = count;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			presc <= '0;
			count <= COUNT_RESET;
			ovf <= 1'b0;
		end else begin
			presc <= next_presc;
			count <= next_count;
			ovf <= next_ovf;
		end
	end

	assign status.count = count;
	assign status.overflow = ovf;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_OVF_ALIGNED: assert property (ovf |-> ($past(count) & $past(mask)) == $past(mask))
		else $error("overflow not aligned to selected period");
	AST_COUNT_RESET: assert property ($past(srst) |-> count == COUNT_RESET)
		else $error("interval count not zero after reset");
endmodule

// *** itw_watchdog.sv ***
// Watchdog counter advanced by interval overflows, with match detect
`timescale 1ns/1ps
module itw_watchdog
	import itw_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire itw_wdog_cfg_t cfg,
	input wire logic advance,
	input wire logic clear,
	output logic [REG_W-1:0] count,
	output logic match
);
	logic [REG_W-1:0] next_count;
	logic [REG_W-1:0] step;
	logic next_match;
	logic go;

	always_comb begin
		go = advance && cfg.enable && !clear;
		step = (count == cfg.match) ? COUNT_RESET : count + COUNT_STEP;
		next_match = go && (step == cfg.match);
		if (clear) begin
			next_count = COUNT_RESET;
		end else if (go) begin
			next_count = step;
		end else begin
			next_count = count;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			count <= COUNT_RESET;
			match <= 1'b0;
		end else begin
			count <= next_count;
			match <= next_match;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_WD_ADVANCE: assert property (go && count != cfg.match |=> count == $past(count) + COUNT_STEP)
		else $error("watchdog count did not advance by one");
	AST_WD_RESTART: assert property (go && count == cfg.match |=> count == COUNT_RESET)
		else $error("watchdog count did not restart after match");
	AST_WD_HOLD: assert property (!cfg.enable && !clear |=> $stable(count))
		else $error("disabled watchdog count moved");
	AST_WD_MATCH: assert property (match |-> count == $past(cfg.match))
		else $error("match pulse without equal count");
endmodule

// *** itw_top.sv ***
// Top: AXI4-Lite slave, registers, interval timer, watchdog, interrupt
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
// Contract
// - Three-bit select sets overflow period 0.512 to 65.536 ms, default 16.384 ms
// - Interval count is a read-only register at 8CH, zero after reset
// - Writing one to interval clear zeroes the counter; the bit self-clears
// - Interval timer never stops; overflow sets a flag cleared by writing zero
// - Mode bit 6 chooses interval timer or watchdog reset operation
// - Writing one to mode bit 5 zeroes watchdog count; bit self-clears
// - Watchdog count equal to match value raises the watchdog flag
// - On match: interrupt request if reset operation off, CPU reset if on
// - Watchdog count advances once per overflow; interval is period times match plus one
// - Match value is write-only at 8EH, resets to FFH
// - Reading 8EH returns the watchdog count, zero after reset
// - Mode bit 7 enables the watchdog; zero after reset
// - Mode bit 0 flag sets on match; cleared by writing zero or acknowledge
// - Mode register at 8DH, reset 00H, bits 4 to 1 unused
module itw_top
	import itw_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [DATA_W-1:0] S_AXI_WDATA,
	input wire logic [DATA_W/8-1:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	input wire logic INT_ACK,
	output logic IRQ,
	output logic CPU_RST
);
	// Bus state
	logic aw_held;
	logic next_aw_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [ADDR_W-1:0] next_aw_addr;
	logic w_held;
	logic next_w_held;
	logic [REG_W-1:0] w_data;
	logic [REG_W-1:0] next_w_data;
	logic w_lane;
	logic next_w_lane;
	logic bvalid;
	logic next_bvalid;
	logic [1:0] bresp;
	logic [1:0] next_bresp;
	logic rvalid;
	logic next_rvalid;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] next_rdata;
	logic [1:0] rresp;
	logic [1:0] next_rresp;
	logic wr_go;
	logic [IDX_W-1:0] wr_idx;
	logic [IDX_W-1:0] rd_idx;
	logic [DATA_W-1:0] rd_word;

	// Control state
	logic [SEL_W-1:0] period_sel;
	logic [SEL_W-1:0] next_period_sel;
	logic interval_clear;
	logic next_interval_clear;
	logic interval_overflow_flag;
	logic next_interval_overflow_flag;
	itw_wdog_cfg_t wd_cfg;
	itw_wdog_cfg_t next_wd_cfg;
	logic watchdog_clear;
	logic next_watchdog_clear;
	logic watchdog_irq_flag;
	logic next_watchdog_irq_flag;
	logic [ST_W-1:0] irq_status;
	logic [ST_W-1:0] next_irq_status;
	logic [ST_W-1:0] irq_mask;
	logic [ST_W-1:0] next_irq_mask;
	logic cpu_rst;
	logic next_cpu_rst;

	itw_interval_t itv;
	logic [REG_W-1:0] watchdog_count;
	logic wd_match;

	itw_interval_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_interval (
		.clk(REF_CLK),
		.srst(SRST),
		.period_sel(period_sel),
		.clear(interval_clear),
		.status(itv)
	);

	itw_watchdog u_watchdog (
		.clk(REF_CLK),
		.srst(SRST),
		.cfg(wd_cfg),
		.advance(itv.overflow),
		.clear(watchdog_clear),
		.count(watchdog_count),
		.match(wd_match)
	);

	// Register read view
	always_comb begin
		rd_idx = itw_index(S_AXI_ARADDR);
		rd_word = '0;
		case (rd_idx)
			IDX_INTERVAL_CTRL: begin
				rd_word[CTL_FLAG] = interval_overflow_flag;
				rd_word[CTL_CLEAR] = interval_clear;
				rd_word[CTL_SEL_LSB +: SEL_W] = period_sel;
			end
			IDX_INTERVAL_COUNT: rd_word[REG_W-1:0] = itv.count;
			IDX_WDOG_MODE: begin
				rd_word[MODE_EN] = wd_cfg.enable;
				rd_word[MODE_RST] = wd_cfg.reset_on;
				rd_word[MODE_CLR] = watchdog_clear;
				rd_word[MODE_IRQ] = watchdog_irq_flag;
			end
			IDX_WDOG_MATCH: rd_word[REG_W-1:0] = watchdog_count;
			IDX_IRQ_STATUS: rd_word[ST_W-1:0] = irq_status;
			IDX_IRQ_MASK: rd_word[ST_W-1:0] = irq_mask;
			default: rd_word = '0;
		endcase
	end

	// AXI4-Lite handshakes, one write and one read at a time
	always_comb begin
		wr_go = aw_held && w_held && !bvalid;
		wr_idx = itw_index(aw_addr);
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_lane = w_lane;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_aw_held = 1'b1;
			next_aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_w_held = 1'b1;
			next_w_data = S_AXI_WDATA[REG_W-1:0];
			next_w_lane = S_AXI_WSTRB[0];
		end
		if (wr_go) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = itw_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && S_AXI_BREADY) begin
			next_bvalid = 1'b0;
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			next_rvalid = 1'b1;
			next_rdata = rd_word;
			next_rresp = itw_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && S_AXI_RREADY) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= '0;
			w_lane <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_lane <= next_w_lane;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// Register writes and hardware events; events win over clears
	always_comb begin
		next_period_sel = period_sel;
		next_interval_clear = 1'b0;
		next_interval_overflow_flag = interval_overflow_flag;
		next_wd_cfg = wd_cfg;
		next_watchdog_clear = 1'b0;
		next_watchdog_irq_flag = watchdog_irq_flag;
		next_irq_status = irq_status;
		next_irq_mask = irq_mask;
		if (wr_go && w_lane) begin
			case (wr_idx)
				IDX_INTERVAL_CTRL: begin
					next_period_sel = w_data[CTL_SEL_LSB +: SEL_W];
					next_interval_clear = w_data[CTL_CLEAR];
					if (!w_data[CTL_FLAG]) begin
						next_interval_overflow_flag = 1'b0;
					end
				end
				IDX_WDOG_MODE: begin
					next_wd_cfg.enable = w_data[MODE_EN];
					next_wd_cfg.reset_on = w_data[MODE_RST];
					next_watchdog_clear = w_data[MODE_CLR];
					if (!w_data[MODE_IRQ]) begin
						next_watchdog_irq_flag = 1'b0;
					end
				end
				IDX_WDOG_MATCH: begin
					next_wd_cfg.match = w_data;
				end
				IDX_IRQ_STATUS: begin
					next_irq_status = irq_status & ~w_data[ST_W-1:0];
				end
				IDX_IRQ_MASK: begin
					next_irq_mask = w_data[ST_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (INT_ACK) begin
			next_watchdog_irq_flag = 1'b0;
		end
		if (itv.overflow) begin
			next_interval_overflow_flag = 1'b1;
			next_irq_status[ST_OVF] = 1'b1;
		end
		if (wd_match) begin
			next_watchdog_irq_flag = 1'b1;
			if (!wd_cfg.reset_on) begin
				next_irq_status[ST_MATCH] = 1'b1;
			end
		end
		next_cpu_rst = wd_match && wd_cfg.reset_on;
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			period_sel <= SEL_RESET;
			interval_clear <= 1'b0;
			interval_overflow_flag <= 1'b0;
			wd_cfg.enable <= 1'b0;
			wd_cfg.reset_on <= 1'b0;
			wd_cfg.match <= MATCH_RESET;
			watchdog_clear <= 1'b0;
			watchdog_irq_flag <= 1'b0;
			irq_status <= '0;
			irq_mask <= '0;
			cpu_rst <= 1'b0;
		end else begin
			period_sel <= next_period_sel;
			interval_clear <= next_interval_clear;
			interval_overflow_flag <= next_interval_overflow_flag;
			wd_cfg <= next_wd_cfg;
			watchdog_clear <= next_watchdog_clear;
			watchdog_irq_flag <= next_watchdog_irq_flag;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			cpu_rst <= next_cpu_rst;
		end
	end

	assign S_AXI_AWREADY = !aw_held && !bvalid;
	assign S_AXI_WREADY = !w_held && !bvalid;
	assign S_AXI_BVALID = bvalid;
	assign S_AXI_BRESP = bresp;
	assign S_AXI_ARREADY = !rvalid;
	assign S_AXI_RVALID = rvalid;
	assign S_AXI_RDATA = rdata;
	assign S_AXI_RRESP = rresp;
	assign IRQ = |(irq_status & irq_mask);
	assign CPU_RST = cpu_rst;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	sequence s_itv_cleared;
		itv.count == COUNT_RESET && !interval_clear;
	endsequence
	sequence s_wd_cleared;
		watchdog_count == COUNT_RESET && !watchdog_clear;
	endsequence

	AST_PERIOD_DEFAULT: assert property ($past(SRST) |-> period_sel == SEL_RESET)
		else $error("period select not at default after reset");
	AST_ITV_CLEAR: assert property (interval_clear |=> s_itv_cleared)
		else $error("interval clear did not zero and release");
	AST_OVF_FLAG: assert property (itv.overflow |=> interval_overflow_flag)
		else $error("overflow flag not set");
	AST_WD_CLEAR: assert property (watchdog_clear |=> s_wd_cleared)
		else $error("watchdog clear did not zero and release");
	AST_MATCH_FLAG: assert property (wd_match |=> watchdog_irq_flag)
		else $error("watchdog flag not raised on match");
	AST_MATCH_RESET: assert property (wd_match && wd_cfg.reset_on |=> CPU_RST ##1 !CPU_RST)
		else $error("cpu reset pulse missing on match");
	AST_MATCH_IRQ: assert property (wd_match && !wd_cfg.reset_on |=> irq_status[ST_MATCH])
		else $error("interrupt status not set on match");
	AST_NO_RST_TIMER: assert property (!$past(wd_cfg.reset_on) |-> !CPU_RST)
		else $error("cpu reset in interval timer operation");
	AST_MATCH_DEFAULT: assert property ($past(SRST) |-> wd_cfg.match == MATCH_RESET)
		else $error("match value not FFH after reset");
	AST_COUNT_READ: assert property (S_AXI_ARVALID && S_AXI_ARREADY && rd_idx == IDX_WDOG_MATCH
		|=> S_AXI_RDATA[REG_W-1:0] == $past(watchdog_count))
		else $error("read of 8EH did not return watchdog count");
	AST_ACK_CLEAR: assert property (INT_ACK && !wd_match |=> !watchdog_irq_flag)
		else $error("acknowledge did not clear watchdog flag");
	AST_MODE_UNUSED: assert property (S_AXI_RVALID && $past(rd_idx) == IDX_WDOG_MODE
		&& $rose(S_AXI_RVALID) |-> S_AXI_RDATA[MODE_CLR-1:MODE_IRQ+1] == '0)
		else $error("unused mode bits read nonzero");
endmodule

// *** itw_tb.sv ***
// Testbench: bus-level tests of the interval timer and watchdog
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb
	import itw_pkg::*;
;
	localparam int TICKS = 4;
	logic REF_CLK = 1'b0;
	logic SRST = 1'b1;
	logic S_AXI_AWVALID = 1'b0;
	logic S_AXI_AWREADY;
	logic [ADDR_W-1:0] S_AXI_AWADDR = '0;
	logic S_AXI_WVALID = 1'b0;
	logic S_AXI_WREADY;
	logic [DATA_W-1:0] S_AXI_WDATA = '0;
	logic [DATA_W/8-1:0] S_AXI_WSTRB = '0;
	logic S_AXI_BVALID;
	logic S_AXI_BREADY = 1'b0;
	logic [1:0] S_AXI_BRESP;
	logic S_AXI_ARVALID = 1'b0;
	logic S_AXI_ARREADY;
	logic [ADDR_W-1:0] S_AXI_ARADDR = '0;
	logic S_AXI_RVALID;
	logic S_AXI_RREADY = 1'b0;
	logic [DATA_W-1:0] S_AXI_RDATA;
	logic [1:0] S_AXI_RRESP;
	logic INT_ACK = 1'b0;
	logic IRQ;
	logic CPU_RST;
	int mismatches = 0;
	int n_checks = 0;
	logic [1:0] resp;
	logic [REG_W-1:0] data;
	logic [REG_W-1:0] held;
	realtime t0;
	realtime t1;

	itw_top #(.TICK_CYCLES(TICKS)) dut (.REF_CLK(REF_CLK), .SRST(SRST),
		.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
		.INT_ACK(INT_ACK), .IRQ(IRQ), .CPU_RST(CPU_RST));

	always #2.5 REF_CLK = ~REF_CLK;

	task automatic bus_write(input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] val,
		output logic [1:0] rsp);
		logic aw_t;
		logic w_t;
		logic aw_s;
		logic w_s;
		logic b_s;
		@(posedge REF_CLK);
		S_AXI_AWVALID <= 1'b1;
		S_AXI_AWADDR <= {idx, 2'b00};
		S_AXI_WVALID <= 1'b1;
		S_AXI_WDATA <= {24'h000000, val};
		S_AXI_WSTRB <= 4'hF;
		S_AXI_BREADY <= 1'b1;
		aw_t = 1'b0;
		w_t = 1'b0;
		b_s = 1'b0;
		while (!(aw_t && w_t)) begin
			@(negedge REF_CLK);
			aw_s = !aw_t && S_AXI_AWREADY;
			w_s = !w_t && S_AXI_WREADY;
			@(posedge REF_CLK);
			if (aw_s) begin
				S_AXI_AWVALID <= 1'b0;
				aw_t = 1'b1;
			end
			if (w_s) begin
				S_AXI_WVALID <= 1'b0;
				w_t = 1'b1;
			end
		end
		while (!b_s) begin
			@(negedge REF_CLK);
			b_s = S_AXI_BVALID;
			rsp = S_AXI_BRESP;
			@(posedge REF_CLK);
		end
		S_AXI_BREADY <= 1'b0;
	endtask

	task automatic bus_read(input logic [IDX_W-1:0] idx, output logic [REG_W-1:0] val,
		output logic [1:0] rsp);
		logic a_s;
		logic r_s;
		@(posedge REF_CLK);
		S_AXI_ARVALID <= 1'b1;
		S_AXI_ARADDR <= {idx, 2'b00};
		S_AXI_RREADY <= 1'b1;
		a_s = 1'b0;
		r_s = 1'b0;
		while (!r_s) begin
			@(negedge REF_CLK);
			r_s = S_AXI_RVALID;
			val = S_AXI_RDATA[REG_W-1:0];
			rsp = S_AXI_RRESP;
			a_s = S_AXI_ARREADY && S_AXI_ARVALID;
			@(posedge REF_CLK);
			if (a_s) begin
				S_AXI_ARVALID <= 1'b0;
			end
		end
		S_AXI_RREADY <= 1'b0;
	endtask

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] val);
		logic [1:0] rsp;
		bus_write(idx, val, rsp);
		`CHK(rsp, RESP_OKAY)
	endtask

	task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] exp);
		logic [REG_W-1:0] val;
		logic [1:0] rsp;
		bus_read(idx, val, rsp);
		`CHK(val, exp)
		`CHK(rsp, RESP_OKAY)
	endtask

	task automatic wait_hi(input bit use_rst, output realtime t);
		do begin
			@(negedge REF_CLK);
		end while ((use_rst ? CPU_RST : IRQ) !== 1'b1);
		t = $realtime;
	endtask

	// Spacing of two watchdog interrupts, clearing the status bit between them
	task automatic measure(input int exp);
		realtime ta;
		realtime tb_;
		realtime tc;
		wait_hi(1'b0, ta);
		wr(IDX_IRQ_STATUS, 8'h02);
		wait_hi(1'b0, tb_);
		wr(IDX_IRQ_STATUS, 8'h02);
		wait_hi(1'b0, tc);
		`CHK(int'((tc - tb_) / 5.0), exp)
	endtask

	task automatic print_verdict();
		if (mismatches == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge REF_CLK);
		mismatches++;
		print_verdict();
	end

	initial begin
		repeat (2) @(posedge REF_CLK);
		SRST <= 1'b0;
		rd_chk(IDX_INTERVAL_CTRL, 8'h05);
		rd_chk(IDX_WDOG_MODE, 8'h00);
		rd_chk(IDX_WDOG_MATCH, 8'h00);
		rd_chk(IDX_IRQ_STATUS, 8'h00);
		rd_chk(IDX_IRQ_MASK, 8'h00);
		`CHK(CPU_RST, 1'b0)
		bus_write(8'h00, 8'h55, resp);
		`CHK(resp, RESP_SLVERR)
		bus_read(8'h00, data, resp);
		`CHK(resp, RESP_SLVERR)
		`CHK(data, 8'h00)
		wr(IDX_WDOG_MODE, 8'h9E);
		rd_chk(IDX_WDOG_MODE, 8'h80);
		wr(IDX_INTERVAL_CTRL, 8'h00);
		wr(IDX_IRQ_MASK, 8'h02);
		measure(2 * TICKS * 256);
		rd_chk(IDX_WDOG_MODE, 8'h81);
		wr(IDX_WDOG_MODE, 8'h80);
		rd_chk(IDX_WDOG_MODE, 8'h80);
		wr(IDX_IRQ_STATUS, 8'h02);
		wait_hi(1'b0, t0);
		@(posedge REF_CLK);
		INT_ACK <= 1'b1;
		@(posedge REF_CLK);
		INT_ACK <= 1'b0;
		rd_chk(IDX_WDOG_MODE, 8'h80);
		wr(IDX_WDOG_MATCH, 8'h02);
		for (int s = 0; s < 8; s++) begin
			wr(IDX_INTERVAL_CTRL, s[REG_W-1:0]);
			measure((2 ** (s + 1)) * TICKS * 3);
		end
		rd_chk(IDX_INTERVAL_CTRL, 8'h87);
		rd_chk(IDX_IRQ_STATUS, 8'h03);
		// Zeroed count keeps the next overflow far away from the mask checks
		wr(IDX_INTERVAL_CTRL, 8'h0F);
		rd_chk(IDX_INTERVAL_CTRL, 8'h07);
		bus_read(IDX_INTERVAL_COUNT, data, resp);
		`CHK(data < 8'h04, 1'b1)
		wr(IDX_IRQ_MASK, 8'h00);
		`CHK(IRQ, 1'b0)
		wr(IDX_IRQ_MASK, 8'h01);
		`CHK(IRQ, 1'b1)
		wr(IDX_IRQ_STATUS, 8'h03);
		`CHK(IRQ, 1'b0)
		rd_chk(IDX_IRQ_STATUS, 8'h00);
		wr(IDX_WDOG_MATCH, 8'hFF);
		wr(IDX_INTERVAL_CTRL, 8'h00);
		repeat (300) @(posedge REF_CLK);
		wr(IDX_WDOG_MODE, 8'h00);
		bus_read(IDX_WDOG_MATCH, held, resp);
		repeat (100) @(posedge REF_CLK);
		rd_chk(IDX_WDOG_MATCH, held);
		wr(IDX_WDOG_MODE, 8'h20);
		rd_chk(IDX_WDOG_MATCH, 8'h00);
		rd_chk(IDX_WDOG_MODE, 8'h00);
		wr(IDX_WDOG_MATCH, 8'h02);
		wr(IDX_IRQ_MASK, 8'h02);
		wr(IDX_IRQ_STATUS, 8'h03);
		wr(IDX_WDOG_MODE, 8'hC0);
		wait_hi(1'b1, t0);
		@(negedge REF_CLK);
		`CHK(CPU_RST, 1'b0)
		wait_hi(1'b1, t1);
		`CHK(int'((t1 - t0) / 5.0), 2 * TICKS * 3)
		`CHK(IRQ, 1'b0)
		bus_read(IDX_IRQ_STATUS, data, resp);
		`CHK(data[ST_MATCH], 1'b0)
		print_verdict();
	end
endmodule
